// ### inc/spf_map.svh
// Purpose: Register map, field positions and codes of the serial frame datapath.
// Assumes: 32-bit classic Wishbone, byte addresses.
// Notes:   Definitions only.
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SPF_ADR_RXCTL 8'h00
`define SPF_ADR_TXCTL 8'h04
`define SPF_ADR_STAT  8'h08
`define SPF_ADR_RXDAT 8'h0C
`define SPF_ADR_TXDAT 8'h10

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPF_CTL_W     25
`define SPF_CTL_RST   25'h0000000
`define SPF_F_PHASE   0
`define SPF_F_CNT1    7:1
`define SPF_F_CNT2    14:8
`define SPF_F_BITS1   17:15
`define SPF_F_BITS2   20:18
`define SPF_F_DLY     22:21
`define SPF_F_FSP     23
`define SPF_F_CKP     24

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SPF_ST_RECEIVE_READY_FLAG   0
`define SPF_ST_TRDY   1
`define SPF_ST_RACT   2
`define SPF_ST_TACT   3

// ----------------------------------------
// Element length codes and lengths
// ----------------------------------------
`define SPF_WL_8      3'h0
`define SPF_WL_12     3'h1
`define SPF_WL_16     3'h2
`define SPF_WL_20     3'h3
`define SPF_WL_24     3'h4
`define SPF_WL_32     3'h5
`define SPF_LEN_8     6'h08
`define SPF_LEN_12    6'h0C
`define SPF_LEN_16    6'h10
`define SPF_LEN_20    6'h14
`define SPF_LEN_24    6'h18
`define SPF_LEN_32    6'h20
`define SPF_LEN_ONE   6'h01
`define SPF_LEN_TWO   6'h02

// ----------------------------------------
// Data delay codes
// ----------------------------------------
`define SPF_DLY_0     2'h0
`define SPF_DLY_1     2'h1
`define SPF_DLY_2     2'h2

`endif

// ### inc/spf_pkg.sv
// Purpose: Types of the serial frame datapath.
// Assumes: spf_map.svh holds the numbers.
// Notes:   Wait states count down the data delay.
`include "spf_map.svh"

package spf_pkg;
  typedef logic [31:0]            spf_word_t;
  typedef logic [`SPF_CTL_W-1:0]  spf_ctl_t;
  typedef logic [5:0]             spf_len_t;

  // Gray along TWO -> ONE -> NONE
  typedef enum logic [1:0] {
    SPF_WAIT_NONE = 2'h0,
    SPF_WAIT_ONE  = 2'h1,
    SPF_WAIT_TWO  = 2'h3
  } spf_wait_e;

  typedef struct packed {
    logic       ph;
    logic [6:0] elem;
    logic [4:0] bitn;
  } spf_pos_s;
endpackage : spf_pkg

// ### verilog/spf_datapath.sv
// Purpose: Frame-level receive and transmit datapath of a synchronous serial port.
// Assumes: Bit clocks and syncs arrive asynchronously and far slower than clk_i.
// Notes:   Bit clocks are sampled by clk_i, never used as clocks.
// Function
// - Element count 1..128 per phase
// - Count field n means n+1 elements
// - Phase bit selects single or dual phase
// - Length codes 8, 16, 20, 32 bits
// - Codes 12/24 bits; phase two length used only in dual phase
// - Separate delay 0, 1 or 2 bits
// - Frame start is first active sync cycle
// - Sync recognised only on rising transition
// - Zero delay samples on detection edge
// - Zero delay drives first bit at once
// - Two-bit delay skips framing bit
// - Framing slot left undriven on transmit
// - Back-to-back frames without gap
// - Sync detected on falling edge, then shift; transmit at zero delay detects the sync transition itself
// - Shifter to buffer only when buffer free
// - Receive ready set on next falling edge
// - Reading receive data clears ready
// - Transmit shifter driven out after delay
// - Transmit ready set on next falling edge
// - Writing transmit data clears ready
// - Syncs as often as frame bit count
// - One access per element, any length
// - Polarity bits at zero: normal edges
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`include "spf_map.svh"

module spf_datapath (
  input  wire logic             clk_i,                  // System clock
  input  wire logic             rst_i,                  // Sync reset, high
  input  wire logic [7:0]       wb_adr_i,               // Byte address
  input  wire spf_pkg::spf_word_t wb_dat_i,             // Write data
  input  wire logic             wb_we_i,                // Write enable
  input  wire logic [3:0]       wb_sel_i,               // Byte lanes
  input  wire logic             wb_cyc_i,               // Cycle
  input  wire logic             wb_stb_i,               // Strobe
  output spf_pkg::spf_word_t    wb_dat_o,               // Read data
  output logic                  wb_ack_o,               // Acknowledge
  input  wire logic             receive_bit_clock_i,    // Receive bit clock
  input  wire logic             receive_frame_sync_i,   // Receive sync
  input  wire logic             serial_data_in_i,       // Receive data
  input  wire logic             transmit_bit_clock_i,   // Transmit bit clock
  input  wire logic             transmit_frame_sync_i,  // Transmit sync
  output logic                  serial_data_out_o,      // Transmit data
  output logic                  serial_data_out_oe_o    // Drive enable
);
  import spf_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic spf_len_t elen(input logic [2:0] code);
    case (code)
      `SPF_WL_8:  elen = `SPF_LEN_8;
      `SPF_WL_12: elen = `SPF_LEN_12;
      `SPF_WL_16: elen = `SPF_LEN_16;
      `SPF_WL_20: elen = `SPF_LEN_20;
      `SPF_WL_24: elen = `SPF_LEN_24;
      default:    elen = `SPF_LEN_32;  // Reserved codes undefined
    endcase
  endfunction : elen

  function automatic spf_len_t pos_len(input spf_ctl_t c, input logic ph);
    pos_len = elen(ph ? c[`SPF_F_BITS2] : c[`SPF_F_BITS1]);
  endfunction : pos_len

  function automatic logic [6:0] pos_cnt(input spf_ctl_t c, input logic ph);
    pos_cnt = ph ? c[`SPF_F_CNT2] : c[`SPF_F_CNT1];
  endfunction : pos_cnt

  // Next bit position; wraps to zero after the frame's last bit
  function automatic spf_pos_s pos_step(input spf_pos_s p, input logic lb,
                                        input logic le, input logic lp);
    pos_step = p;
    if (!lb) begin
      pos_step.bitn = p.bitn + 5'h01;
    end else if (!le) begin
      pos_step.bitn = 5'h00;
      pos_step.elem = p.elem + 7'h01;
    end else if (!lp) begin
      pos_step = '{ph: 1'b1, elem: 7'h00, bitn: 5'h00};
    end else begin
      pos_step = '0;
    end
  endfunction : pos_step

  function automatic spf_wait_e wait_of(input logic [1:0] d);
    case (d)
      `SPF_DLY_1: wait_of = SPF_WAIT_ONE;
      `SPF_DLY_2: wait_of = SPF_WAIT_TWO;
      default:    wait_of = SPF_WAIT_NONE;
    endcase
  endfunction : wait_of

  function automatic spf_word_t merge(input spf_word_t o, input spf_word_t n,
                                      input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[i*8 +: 8] = n[i*8 +: 8];
      end
    end
  endfunction : merge

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Stage 0 feeds stage 1 only; stage 2 is the previous value for edges
  logic [2:0] rck_s;
  logic [2:0] rfs_s;
  logic [1:0] rdi_s;
  logic [2:0] tck_s;
  logic [2:0] tfs_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rck_s <= 3'h0;
      rfs_s <= 3'h0;
      rdi_s <= 2'h0;
      tck_s <= 3'h0;
      tfs_s <= 3'h0;
    end else begin
      rck_s <= {rck_s[1:0], receive_bit_clock_i};
      rfs_s <= {rfs_s[1:0], receive_frame_sync_i};
      rdi_s <= {rdi_s[0], serial_data_in_i};
      tck_s <= {tck_s[1:0], transmit_bit_clock_i};
      tfs_s <= {tfs_s[1:0], transmit_frame_sync_i};
    end
  end

  // ----------------------------------------
  // Registers and bus decode
  // ----------------------------------------
  spf_ctl_t  rx_ctl_reg;
  spf_ctl_t  tx_ctl_reg;
  spf_word_t r_dat_reg;
  spf_word_t t_dat_reg;
  logic      r_rdy_reg;
  logic      t_rdy_reg;
  logic      r_act_reg;
  logic      t_act_reg;
  logic      wb_ack_reg;
  spf_word_t wb_dat_reg;

  wire        wb_hit  = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  wire        wb_wr   = wb_hit & wb_we_i;
  wire        wb_rd   = wb_hit & ~wb_we_i;
  wire        a_rxctl = wb_adr_i == `SPF_ADR_RXCTL;
  wire        a_txctl = wb_adr_i == `SPF_ADR_TXCTL;
  wire        a_stat  = wb_adr_i == `SPF_ADR_STAT;
  wire        a_rxdat = wb_adr_i == `SPF_ADR_RXDAT;
  wire        a_txdat = wb_adr_i == `SPF_ADR_TXDAT;
  wire        rd_rxd  = wb_rd & a_rxdat;
  wire        wr_txd  = wb_wr & a_txdat;
  wire [31:0] ctl_rx_w = merge({7'h00, rx_ctl_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] ctl_tx_w = merge({7'h00, tx_ctl_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] stat_w   = {28'h0000000, t_act_reg, r_act_reg, t_rdy_reg, r_rdy_reg};

  // Unmapped addresses read zero and ignore writes
  wire spf_word_t rd_mux =
      a_rxctl ? {7'h00, rx_ctl_reg} :
      a_txctl ? {7'h00, tx_ctl_reg} :
      a_stat  ? stat_w :
      a_rxdat ? r_dat_reg :
      a_txdat ? t_dat_reg : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h00000000;
      rx_ctl_reg <= `SPF_CTL_RST;
      tx_ctl_reg <= `SPF_CTL_RST;
      t_dat_reg  <= 32'h00000000;
    end else begin
      wb_ack_reg <= wb_hit;
      wb_dat_reg <= wb_rd ? rd_mux : 32'h00000000;
      if (wb_wr && a_rxctl) begin
        rx_ctl_reg <= ctl_rx_w[`SPF_CTL_W-1:0];
      end
      if (wb_wr && a_txctl) begin
        tx_ctl_reg <= ctl_tx_w[`SPF_CTL_W-1:0];
      end
      if (wr_txd) begin
        t_dat_reg <= merge(t_dat_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  // ----------------------------------------
  // Receive clock, sync and position
  // ----------------------------------------
  spf_wait_e r_wait_reg;
  spf_pos_s  r_pos_reg;
  logic      r_fsp_reg;
  logic      r_cpy_reg;
  logic      r_full_reg;
  logic      r_pend_reg;
  spf_word_t r_sh_reg;
  spf_word_t r_buf_reg;

  wire [1:0] r_dly   = rx_ctl_reg[`SPF_F_DLY];
  wire       r_ck    = rck_s[1] ^ rx_ctl_reg[`SPF_F_CKP];
  wire       r_ck_d  = rck_s[2] ^ rx_ctl_reg[`SPF_F_CKP];
  wire       r_fall  = r_ck_d & ~r_ck;
  wire       r_rise  = ~r_ck_d & r_ck;
  wire       r_fs    = rfs_s[1] ^ rx_ctl_reg[`SPF_F_FSP];
  wire       r_start = r_fall & r_fs & ~r_fsp_reg;
  wire spf_len_t r_len = pos_len(rx_ctl_reg, r_pos_reg.ph);
  wire       r_lb    = r_pos_reg.bitn == 5'(r_len - `SPF_LEN_ONE);
  wire       r_le    = r_pos_reg.elem == pos_cnt(rx_ctl_reg, r_pos_reg.ph);
  wire       r_lp    = r_pos_reg.ph | ~rx_ctl_reg[`SPF_F_PHASE];
  wire       r_fend  = r_lb & r_le & r_lp;
  // Zero delay: the detection edge itself carries bit one
  wire       r_take  = r_fall & (r_act_reg |
                       (r_start ? (r_dly == `SPF_DLY_0)
                                : (r_wait_reg == SPF_WAIT_ONE)));
  wire       r_act_n = (r_start & (r_dly == `SPF_DLY_0)) |
                       (~r_start & (r_wait_reg == SPF_WAIT_ONE)) |
                       (r_act_reg & ~(r_take & r_fend));
  wire       r_mv    = r_full_reg & ~r_rdy_reg & ~r_pend_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_fsp_reg  <= 1'b0;
      r_wait_reg <= SPF_WAIT_NONE;
      r_act_reg  <= 1'b0;
      r_pos_reg  <= '0;
      r_sh_reg   <= 32'h00000000;
    end else if (r_fall) begin
      r_fsp_reg  <= r_fs;
      r_act_reg  <= r_act_n;
      if (r_start) begin
        r_wait_reg <= wait_of(r_dly);
      end else if (r_wait_reg == SPF_WAIT_TWO) begin
        r_wait_reg <= SPF_WAIT_ONE;    // Framing bit dropped here
      end else begin
        r_wait_reg <= SPF_WAIT_NONE;
      end
      if (r_take) begin
        r_pos_reg <= pos_step(r_pos_reg, r_lb, r_le, r_lp);
        // Fresh element starts from zero so short words read zero-filled
        r_sh_reg  <= (r_pos_reg.bitn == 5'h00) ? {31'h00000000, rdi_s[1]}
                                               : {r_sh_reg[30:0], rdi_s[1]};
      end
    end
  end

  // ----------------------------------------
  // Receive buffer chain and ready flag
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_cpy_reg  <= 1'b0;
      r_full_reg <= 1'b0;
      r_buf_reg  <= 32'h00000000;
      r_pend_reg <= 1'b0;
      r_dat_reg  <= 32'h00000000;
      r_rdy_reg  <= 1'b0;
    end else begin
      if (r_take && r_lb) begin
        r_cpy_reg <= 1'b1;
      end else if (r_rise) begin
        r_cpy_reg <= 1'b0;
      end
      // A full buffer loses the new element rather than its old one
      if (r_rise && r_cpy_reg && !r_full_reg) begin
        r_buf_reg  <= r_sh_reg;
        r_full_reg <= 1'b1;
      end else if (r_mv) begin
        r_full_reg <= 1'b0;
      end
      if (r_mv) begin
        r_dat_reg  <= r_buf_reg;
        r_pend_reg <= 1'b1;
      end else if (r_fall) begin
        r_pend_reg <= 1'b0;
      end
      if (r_fall && r_pend_reg) begin
        r_rdy_reg <= 1'b1;
      end else if (rd_rxd) begin
        r_rdy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmit clock, sync and position
  // ----------------------------------------
  spf_wait_e t_wait_reg;
  spf_pos_s  t_pos_reg;
  logic      t_fsp_reg;
  logic      t_pend_reg;
  spf_word_t t_sh_reg;
  logic      t_do_reg;
  logic      t_oe_reg;

  wire [1:0] t_dly   = tx_ctl_reg[`SPF_F_DLY];
  wire       t_dly0  = t_dly == `SPF_DLY_0;
  wire       t_ck    = tck_s[1] ^ tx_ctl_reg[`SPF_F_CKP];
  wire       t_ck_d  = tck_s[2] ^ tx_ctl_reg[`SPF_F_CKP];
  wire       t_fall  = t_ck_d & ~t_ck;
  wire       t_rise  = ~t_ck_d & t_ck;
  wire       t_fs    = tfs_s[1] ^ tx_ctl_reg[`SPF_F_FSP];
  wire       t_fs_d  = tfs_s[2] ^ tx_ctl_reg[`SPF_F_FSP];
  // Zero delay reacts to the sync itself, not to a clock edge
  wire       t_start = t_dly0 ? (t_fs & ~t_fs_d)
                              : (t_fall & t_fs & ~t_fsp_reg);
  wire spf_len_t t_len = pos_len(tx_ctl_reg, t_pos_reg.ph);
  wire       t_lb    = t_pos_reg.bitn == 5'(t_len - `SPF_LEN_ONE);
  wire       t_le    = t_pos_reg.elem == pos_cnt(tx_ctl_reg, t_pos_reg.ph);
  wire       t_lp    = t_pos_reg.ph | ~tx_ctl_reg[`SPF_F_PHASE];
  wire       t_fend  = t_lb & t_le & t_lp;
  wire       t_adv   = t_rise & t_act_reg;
  wire       t_begin = (t_start & t_dly0) |
                       (t_rise & (t_wait_reg == SPF_WAIT_ONE));
  wire       t_load  = t_begin | (t_adv & t_lb & ~t_fend);
  wire spf_pos_s t_pos_n = t_adv ? pos_step(t_pos_reg, t_lb, t_le, t_lp) : t_pos_reg;
  wire spf_len_t t_ld_len = pos_len(tx_ctl_reg, t_pos_n.ph);
  wire       t_act_n = t_begin | (t_act_reg & ~(t_adv & t_fend));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_fsp_reg  <= 1'b0;
      t_wait_reg <= SPF_WAIT_NONE;
      t_pos_reg  <= '0;
      t_act_reg  <= 1'b0;
    end else begin
      if (t_fall) begin
        t_fsp_reg <= t_fs;
      end
      if (t_start && !t_dly0) begin
        t_wait_reg <= wait_of(t_dly);
      end else if (t_rise && t_wait_reg == SPF_WAIT_TWO) begin
        t_wait_reg <= SPF_WAIT_ONE;
      end else if (t_rise) begin
        t_wait_reg <= SPF_WAIT_NONE;
      end
      t_pos_reg <= t_pos_n;
      t_act_reg <= t_act_n;
    end
  end

  // ----------------------------------------
  // Transmit shifter, pin and ready flag
  // ----------------------------------------
  // Pin is released whenever no data bit is due, framing slot included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_sh_reg   <= 32'h00000000;
      t_do_reg   <= 1'b0;
      t_oe_reg   <= 1'b0;
      t_pend_reg <= 1'b0;
      t_rdy_reg  <= 1'b1;
    end else begin
      t_oe_reg <= t_act_n;
      if (t_load) begin
        t_sh_reg <= t_dat_reg;
        t_do_reg <= t_dat_reg[5'(t_ld_len - `SPF_LEN_ONE)];
      end else if (t_adv) begin
        t_sh_reg <= {t_sh_reg[30:0], 1'b0};
        t_do_reg <= t_sh_reg[5'(t_len - `SPF_LEN_TWO)];
      end
      if (t_load) begin
        t_pend_reg <= 1'b1;
      end else if (t_fall) begin
        t_pend_reg <= 1'b0;
      end
      if (t_fall && t_pend_reg) begin
        t_rdy_reg <= 1'b1;
      end else if (wr_txd) begin
        t_rdy_reg <= 1'b0;
      end
    end
  end

  assign serial_data_out_o    = t_do_reg;
  assign serial_data_out_oe_o = t_oe_reg;
endmodule : spf_datapath

// ### bench/spf_datapath_props.sv
// Purpose: Port-level checks of spf_datapath.
// Assumes: Polarity bits zero; one bus request at a time.
// Notes:   Bound to the design at the foot of this file.
`include "spf_map.svh"
module spf_datapath_props (
  input wire logic               clk_i,                 // Clock
  input wire logic               rst_i,                 // Reset
  input wire logic [7:0]         wb_adr_i,              // Address
  input wire logic               wb_we_i,               // Write
  input wire logic               wb_cyc_i,              // Cycle
  input wire logic               wb_stb_i,              // Strobe
  input wire spf_pkg::spf_word_t wb_dat_o,              // Read data
  input wire logic               wb_ack_o,              // Acknowledge
  input wire logic               transmit_bit_clock_i,  // TX clock
  input wire logic               transmit_frame_sync_i, // TX sync
  input wire logic               serial_data_out_o,     // TX data
  input wire logic               serial_data_out_oe_o   // TX enable
);
  timeunit 1ns;
  timeprecision 100ps;
  import spf_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // ----
  // Sequences
  // ----
  sequence s_req;
    req;
  endsequence
  // Eight quiet cycles cover the pin synchroniser and output register
  sequence s_tx_quiet;
    ($stable(transmit_bit_clock_i) && $stable(transmit_frame_sync_i) && !wb_cyc_i) [*8];
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_dat_quiet: assert property ((!wb_ack_o || $past(wb_we_i)) |-> wb_dat_o == '0)
    else $error("read data outside read ack");
  a_unmapped_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i > `SPF_ADR_TXDAT)
    |=> wb_dat_o == '0) else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(rst_i) |-> !serial_data_out_oe_o)
    else $error("data pin driven after reset");
  a_tx_still: assert property (s_tx_quiet |=> $stable(serial_data_out_o)
    && $stable(serial_data_out_oe_o)) else $error("data pin moved without clock");
  a_oe_on_rise: assert property ($rose(serial_data_out_oe_o)
    |-> $past(transmit_bit_clock_i)) else $error("drive began off rising edge");
endmodule : spf_datapath_props

bind spf_datapath spf_datapath_props u_props (.clk_i, .rst_i, .wb_adr_i, .wb_we_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .transmit_bit_clock_i, .transmit_frame_sync_i,
  .serial_data_out_o, .serial_data_out_oe_o);

// ### bench/spf_codec_model.sv
// Purpose: Behavioural serial codec at the far side of the link.
// Assumes: Polarities zero; 48 ns bit clock shared by both directions.
// Notes:   Clock stands low between runs; idle data toggles every bit.
module spf_codec_model (
  output logic      bit_clock_o,     // Bit clock
  output logic      frame_sync_o,    // Frame sync
  output logic      data_to_dev_o,   // Data into device
  input  wire logic data_from_dev_i, // Data from device
  input  wire logic oe_from_dev_i    // Its drive enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rx_bits[$];
  logic tx_bits[$];
  logic slot_oe;
  initial begin
    bit_clock_o = 1'b0;
    frame_sync_o = 1'b0;
    data_to_dev_o = 1'b0;
    slot_oe = 1'b0;
  end
  task automatic run(input int n, d, fr, sw, extra);
    int  j;
    logic due;
    #1.3;
    for (j = 0; j < fr * n + d + 2 + extra; j++) begin
      due = j >= d && j - d < fr * n;
      bit_clock_o = 1'b1;
      frame_sync_o = (j < fr * n && j % n == 0) || j < sw;
      data_to_dev_o = due ? rx_bits.pop_front() : !data_to_dev_o;
      #24;
      bit_clock_o = 1'b0;
      if (due) tx_bits.push_back(oe_from_dev_i ? data_from_dev_i : 1'bx);
      if (d == 2 && j == 1) slot_oe = oe_from_dev_i;
      #24;
    end
  endtask : run
endmodule : spf_codec_model

// ### bench/serial_port_frame_datapath_tb_top.sv
// Purpose: Self-checking bench of spf_datapath against a codec model.
// Assumes: Polarity bits zero; both directions share one link clock.
// Notes:   Reads flagged for compare are checked by the ack monitor.
`include "spf_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module serial_port_frame_datapath_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import spf_pkg::*;
  logic       clk_i    = 1'b0;
  logic       rst_i    = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  spf_word_t  wb_dat_i = 32'h0;
  logic       wb_we_i  = 1'b0;
  logic       wb_cyc_i = 1'b0;
  logic       wb_stb_i = 1'b0;
  logic       chk      = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [3:0] bsel     = 4'hF;
  spf_word_t  wb_dat_o;
  logic       wb_ack_o, bclk, fsync, sdi, sdo, sdo_oe;
  int         fail_count = 0, num_checks = 0, cycles = 0;
  int         lens[6] = '{8, 12, 16, 20, 24, 32};
  spf_word_t  exp_q[$];
  always #2.5 clk_i = ~clk_i;
  spf_datapath dut_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .receive_bit_clock_i(bclk), .receive_frame_sync_i(fsync),
    .serial_data_in_i(sdi), .transmit_bit_clock_i(bclk), .transmit_frame_sync_i(fsync),
    .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe));
  spf_codec_model codec_u (.bit_clock_o(bclk), .frame_sync_o(fsync), .data_to_dev_o(sdi),
    .data_from_dev_i(sdo), .oe_from_dev_i(sdo_oe));
  // ----
  // Monitor and timeout
  // ----
  always @(posedge clk_i) begin : mon_b
    spf_word_t e;
    cycles++;
    if (cycles > 40000) begin
      fail_count++;
      conclude();
    end else if (wb_ack_o === 1'b1 && chk) begin
      e = exp_q.pop_front();
      `CHK(wb_dat_o, e)
    end
  end
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ----
  // Bus tasks
  // ----
  task automatic bus(input logic we, input logic [7:0] a, input spf_word_t d, input logic c,
                     output spf_word_t r);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, chk} <= {2'b11, we, c};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= bsel;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i, chk} <= 4'h0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input spf_word_t d);
    spf_word_t r;
    bus(1'b1, a, d, 1'b0, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input spf_word_t e);
    spf_word_t r;
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 1'b1, r);
  endtask : rd
  // ----
  // Frame scenario
  // ----
  task automatic run_test(input int ph, c1, w1, c2, w2, d, fr, sw);
    int        ln[$];
    spf_word_t txw[$], rxw[$], ctl, s, v;
    int        k, b, nt, nr;
    logic      t;
    ctl = spf_word_t'(ph | c1 << 1 | c2 << 8 | w1 << 15 | w2 << 18 | d << 21);
    wr(`SPF_ADR_RXCTL, ctl);
    wr(`SPF_ADR_TXCTL, ctl);
    rd(`SPF_ADR_TXCTL, ctl);
    for (k = 0; k < fr; k++) begin
      for (b = 0; b <= c1; b++) ln.push_back(lens[w1]);
      if (ph) for (b = 0; b <= c2; b++) ln.push_back(lens[w2]);
    end
    foreach (ln[i]) begin
      txw.push_back($urandom());
      v = spf_word_t'($urandom() & ((33'h1 << ln[i]) - 33'h1));
      rxw.push_back(v);
      for (b = ln[i] - 1; b >= 0; b--) codec_u.rx_bits.push_back(v[b]);
    end
    wr(`SPF_ADR_TXDAT, txw[0]);
    nt = 1;
    nr = 0;
    fork
      codec_u.run((c1 + 1) * lens[w1] + (ph ? (c2 + 1) * lens[w2] : 0), d, fr, sw, 2);
      while (nr < ln.size()) begin
        bus(1'b0, `SPF_ADR_STAT, 32'h0, 1'b0, s);
        if (s[`SPF_ST_TRDY] === 1'b1 && nt < ln.size()) begin
          wr(`SPF_ADR_TXDAT, txw[nt]);
          nt++;
        end
        if (s[`SPF_ST_RECEIVE_READY_FLAG] === 1'b1) begin
          rd(`SPF_ADR_RXDAT, rxw[nr]);
          nr++;
        end
      end
    join
    repeat (10) @(posedge clk_i);
    foreach (ln[i]) for (b = ln[i] - 1; b >= 0; b--) begin
      t = codec_u.tx_bits.pop_front();
      `CHK(t, txw[i][b])
    end
    if (d == 2) `CHK(codec_u.slot_oe, 1'b0)
    rd(`SPF_ADR_STAT, 32'h2);
  endtask : run_test
  // ----
  // Main sequence
  // ----
  initial begin : main_b
    spf_word_t s;
    int        c;
    void'($urandom(80));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SPF_ADR_STAT, 32'h2);
    bus(1'b1, `SPF_ADR_STAT, 32'hF, 1'b0, s);
    rd(`SPF_ADR_STAT, 32'h2);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h0);
    rd(`SPF_ADR_RXCTL, 32'h0);
    // Byte lane select: only the low byte may land
    bsel = 4'h1;
    wr(`SPF_ADR_RXCTL, 32'hFFFFFFFF);
    bsel = 4'hF;
    rd(`SPF_ADR_RXCTL, 32'h000000FF);
    for (c = 0; c < 6; c++) run_test(0, 0, c, 0, 0, c % 3, 1, 0);
    run_test(1, 1, 1, 2, 0, 1, 2, 0);
    run_test(0, 3, 0, 0, 0, 0, 2, 0);
    run_test(0, 0, 2, 0, 0, 2, 3, 0);
    run_test(0, 0, 0, 5, 3, 1, 1, 12);
    run_test(0, 127, 0, 0, 0, 1, 1, 0);
    conclude();
  end
endmodule : serial_port_frame_datapath_tb_top
